// ===== include/ettc_pkg.sv
/*
 * ettc_pkg: addresses, field positions, reset values and mode codes of the
 * eight-bit timer with capture and pwm.
 * assumes: the cpu register port presents 8-bit addresses and 8-bit data.
 */
package ettc_pkg;

    // register addresses on the cpu register port
    localparam logic [7:0] TIMER_CONTROL_ADDR = 8'he1;
    localparam logic [7:0] TIMER_PRESCALE_SELECT_ADDR = 8'he2;
    localparam logic [7:0] TIMER_REFERENCE_ADDR = 8'he3;
    localparam logic [7:0] TIMER_COUNTER_ADDR = 8'he4;
    localparam logic [7:0] TIMER_STATUS_ADDR = 8'he6;
    localparam logic [7:0] PORT_ONE_CONFIG_ADDR = 8'he7;

    // reset values
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TIMER_PRESCALE_RESET = 8'h00;
    localparam logic [7:0] TIMER_REFERENCE_RESET = 8'hff;
    localparam logic [7:0] PORT_ONE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] OVERFLOW_VECTOR = 8'hd0;

    // timer_control fields
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_CLEAR_BIT = 5;
    localparam int CTRL_MATCH_IE_BIT = 3;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_MATCH_PEND_BIT = 1;
    localparam int CTRL_OVF_IE_BIT = 0;

    // timer_prescale_select fields
    localparam int PRE_EDGE_BIT = 5;
    localparam int PRE_EXT_BIT = 4;
    localparam int PRE_DIV_HI = 3;
    localparam int PRE_DIV_LO = 0;
    localparam logic [3:0] PRE_DIV_MAX = 4'hc;
    localparam int PRE_WIDTH = 12;

    // timer_status fields
    localparam int STAT_OVF_PEND_BIT = 0;

    // port_one_config capture pin field
    localparam int P1_CAP_HI = 3;
    localparam int P1_CAP_LO = 2;

    typedef enum logic [1:0]
    {
        ETTC_INTERVAL = 2'b00,
        ETTC_CAPTURE = 2'b01,
        ETTC_PWM = 2'b11,
        ETTC_SPARE = 2'b10
    } ettc_mode_type;

endpackage

// ===== rtl/ettc_timer.sv
/*
 * ettc_timer: eight-bit timer/counter with interval, capture and pwm modes,
 * a prescaler from the oscillator clock or an external clock pin, and the
 * overflow and match/capture interrupt requests.
 * assumes: clk is the oscillator clock; pins arrive asynchronously; the cpu
 * register port is synchronous to clk with a one-cycle write strobe.
 */
`timescale 1ns/1ns

// How it works
// - three modes chosen by the control mode field
// - prescaler divides oscillator by one up to 4096
// - prescale register picks internal or external clock
// - eight-bit counter, comparator and reference register
// - interval match toggles pin, sets pending, clears counter
// - pwm match leaves counter running and wrapping
// - pwm pin low when reference not above counter
// - pwm period is 256 prescaled clocks
// - chosen capture pin edge copies counter to reference
// - port field 0x selects capture, 1x output
// - capture mode raises overflow and capture pendings
// - overflow pending cleared by service or software
// - control register resets to zero
// - writing one to bit 5 clears counter
// - bit 2 starts and stops the counter
// - overflow request carries vector d0
// - match/capture request only when bit 3 set
module ettc_timer
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // cpu register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // pins
    input wire logic externalClockPin,
    input wire logic captureInputPin,
    output logic timerOutputPin,
    output logic timerOutputOe_n,
    // interrupt controller
    input wire logic overflowAck,
    output logic overflowIrq,
    output logic [7:0] overflowVector,
    output logic matchCaptureIrq
);

    function automatic logic [ettc_pkg::PRE_WIDTH-1:0] divMask(input logic [3:0] sel);
        logic [ettc_pkg::PRE_WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < ettc_pkg::PRE_WIDTH; i++)
        begin
            if (i < int'(sel))
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    logic [7:0] control_q;
    logic [7:0] prescale_q;
    logic [7:0] reference_q;
    logic [7:0] counter_q;
    logic [7:0] counter_d;
    logic [7:0] portCfg_q;
    logic ovfPend_q;
    logic [ettc_pkg::PRE_WIDTH-1:0] pre_q;
    logic [2:0] extSync_q;
    logic [2:0] capSync_q;
    logic ctrlWr;
    logic tick;
    logic running;
    logic matchHit;
    logic wrap;
    logic capEdge;
    logic captureOn;
    logic matchSet;
    ettc_pkg::ettc_mode_type mode;

    assign ctrlWr = regWrite && isAddr(regAddr, ettc_pkg::TIMER_CONTROL_ADDR);
    // spare code behaves as interval so every code is defined
    assign mode = ettc_pkg::ettc_mode_type'(control_q[ettc_pkg::CTRL_MODE_HI:
                                                      ettc_pkg::CTRL_MODE_LO]);
    assign running = control_q[ettc_pkg::CTRL_RUN_BIT];

    // pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // reset matches the idle low level of both pins, so no false edge
            extSync_q <= 3'h0;
            capSync_q <= 3'h0;
        end
        else
        begin
            extSync_q <= {extSync_q[1:0], externalClockPin};
            capSync_q <= {capSync_q[1:0], captureInputPin};
        end
    end

    // prescaler free-runs so a rate change takes effect within one period
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_q <= '0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_comb
    begin
        logic [3:0] sel;
        sel = prescale_q[ettc_pkg::PRE_DIV_HI:ettc_pkg::PRE_DIV_LO];
        if (sel > ettc_pkg::PRE_DIV_MAX)
        begin
            sel = ettc_pkg::PRE_DIV_MAX;
        end
        if (prescale_q[ettc_pkg::PRE_EXT_BIT])
        begin
            tick = extSync_q[1] && !extSync_q[2];
        end
        else
        begin
            tick = (pre_q | ~divMask(sel)) == '1;
        end
    end

    assign captureOn = (mode == ettc_pkg::ETTC_CAPTURE)
                       && !portCfg_q[ettc_pkg::P1_CAP_HI];
    // edge bit set: falling edge, clear: rising edge
    assign capEdge = captureOn && (prescale_q[ettc_pkg::PRE_EDGE_BIT]
                     ? (!capSync_q[1] && capSync_q[2])
                     : (capSync_q[1] && !capSync_q[2]));

    assign matchHit = running && tick && (counter_q == reference_q);
    // an interval match back to zero does not count as an overflow
    assign wrap = running && tick && (counter_q == 8'hff)
                  && !(matchHit && (mode == ettc_pkg::ETTC_INTERVAL
                                    || mode == ettc_pkg::ETTC_SPARE));

    always_comb
    begin
        counter_d = counter_q;
        if (running && tick)
        begin
            unique case (mode)
                ettc_pkg::ETTC_INTERVAL,
                ettc_pkg::ETTC_SPARE:
                begin
                    counter_d = matchHit ? 8'h00 : counter_q + 8'h01;
                end
                ettc_pkg::ETTC_CAPTURE,
                ettc_pkg::ETTC_PWM:
                begin
                    counter_d = counter_q + 8'h01;
                end
            endcase
        end
        // software clear beats a tick in the same cycle
        if (ctrlWr && regWrData[ettc_pkg::CTRL_CLEAR_BIT])
        begin
            counter_d = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            counter_q <= 8'h00;
        end
        else
        begin
            counter_q <= counter_d;
        end
    end

    assign matchSet = (matchHit && mode != ettc_pkg::ETTC_CAPTURE
                       && mode != ettc_pkg::ETTC_PWM) || capEdge;

    // control register; clear bit is a strobe and never stored
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            control_q <= ettc_pkg::TIMER_CONTROL_RESET;
        end
        else
        begin
            // bit 4 has no function but reads back as written
            if (ctrlWr)
            begin
                control_q[7:6] <= regWrData[7:6];
                control_q[4:2] <= regWrData[4:2];
                control_q[0] <= regWrData[0];
            end
            control_q[ettc_pkg::CTRL_CLEAR_BIT] <= 1'b0;
            // a match in the clearing cycle is kept
            if (matchSet)
            begin
                control_q[ettc_pkg::CTRL_MATCH_PEND_BIT] <= 1'b1;
            end
            else if (ctrlWr && !regWrData[ettc_pkg::CTRL_MATCH_PEND_BIT])
            begin
                control_q[ettc_pkg::CTRL_MATCH_PEND_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prescale_q <= ettc_pkg::TIMER_PRESCALE_RESET;
            portCfg_q <= ettc_pkg::PORT_ONE_CONFIG_RESET;
        end
        else if (regWrite)
        begin
            if (isAddr(regAddr, ettc_pkg::TIMER_PRESCALE_SELECT_ADDR))
            begin
                prescale_q <= regWrData;
            end
            if (isAddr(regAddr, ettc_pkg::PORT_ONE_CONFIG_ADDR))
            begin
                portCfg_q <= regWrData;
            end
        end
    end

    // capture has priority over a software write in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reference_q <= ettc_pkg::TIMER_REFERENCE_RESET;
        end
        else if (capEdge)
        begin
            reference_q <= counter_q;
        end
        else if (regWrite && isAddr(regAddr, ettc_pkg::TIMER_REFERENCE_ADDR))
        begin
            reference_q <= regWrData;
        end
    end

    // overflow pending: set wins over service and software clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ovfPend_q <= 1'b0;
        end
        else if (wrap)
        begin
            ovfPend_q <= 1'b1;
        end
        else if (overflowAck || (regWrite && isAddr(regAddr, ettc_pkg::TIMER_STATUS_ADDR)
                 && !regWrData[ettc_pkg::STAT_OVF_PEND_BIT]))
        begin
            ovfPend_q <= 1'b0;
        end
    end

    // output pin: toggle in interval, compare in pwm, released in capture
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timerOutputPin <= 1'b0;
            timerOutputOe_n <= 1'b1;
        end
        else
        begin
            // enable registered beside the pin so both change on one edge
            timerOutputOe_n <= (mode == ettc_pkg::ETTC_CAPTURE);
            if (mode == ettc_pkg::ETTC_PWM)
            begin
                timerOutputPin <= reference_q > counter_q;
            end
            else if (matchSet && mode != ettc_pkg::ETTC_CAPTURE)
            begin
                timerOutputPin <= !timerOutputPin;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            overflowIrq <= 1'b0;
            matchCaptureIrq <= 1'b0;
            overflowVector <= 8'h00;
        end
        else
        begin
            // requests are levels that stand until their pending bit clears
            overflowIrq <= ovfPend_q && control_q[ettc_pkg::CTRL_OVF_IE_BIT];
            matchCaptureIrq <= control_q[ettc_pkg::CTRL_MATCH_PEND_BIT]
                               && control_q[ettc_pkg::CTRL_MATCH_IE_BIT];
            overflowVector <= ettc_pkg::OVERFLOW_VECTOR;
        end
    end

    // read data registered one cycle after the address
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            // counter reads back; writes to its address are dropped
            unique case (regAddr)
                ettc_pkg::TIMER_CONTROL_ADDR: regRdData <= control_q;
                ettc_pkg::TIMER_PRESCALE_SELECT_ADDR: regRdData <= prescale_q;
                ettc_pkg::TIMER_REFERENCE_ADDR: regRdData <= reference_q;
                ettc_pkg::TIMER_COUNTER_ADDR: regRdData <= counter_q;
                ettc_pkg::TIMER_STATUS_ADDR: regRdData <= {7'h00, ovfPend_q};
                ettc_pkg::PORT_ONE_CONFIG_ADDR: regRdData <= portCfg_q;
                default: regRdData <= 8'h00;
            endcase
        end
    end

endmodule

// ===== verif/ettc_pins_model.sv
/* ettc_pins_model: external count clock and capture pin.
   assumes: tasks are called at a falling clock edge. */
`timescale 1ns/1ns
module ettc_pins_model
(
    // pins toward the timer
    output logic extClkPin,
    output logic capPin
);
    // count clock stands low between bursts
    initial
    begin
        extClkPin = 1'b0;
        capPin = 1'b0;
    end
    // half sets prompt or slow pulses
    task automatic pulse(input int n, input int half);
        repeat (n)
        begin
            #(half) extClkPin = 1'b1;
            #(half) extClkPin = 1'b0;
        end
    endtask
    task automatic drive_cap(input logic v);
        capPin = v;
    endtask
endmodule

// ===== verif/ettc_timer_chk.sv
/* ettc_timer_chk: port-level assertions on ettc_timer.
   assumes: one clock domain; bound to ettc_timer below. */
`timescale 1ns/1ns
module ettc_timer_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    // pin and requests
    input wire logic timerOutputPin,
    input wire logic timerOutputOe_n,
    input wire logic overflowAck,
    input wire logic overflowIrq,
    input wire logic [7:0] overflowVector,
    input wire logic matchCaptureIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence ctrl_wr;
        regWrite && regAddr == 8'he1;
    endsequence
    vector_fixed_a: assert property ($past(arst_n) |-> overflowVector == 8'hd0)
        else $error("overflow vector wrong");
    unmapped_zero_a: assert property ($past(arst_n) && !($past(regAddr) inside
        {8'he1, 8'he2, 8'he3, 8'he4, 8'he6, 8'he7}) |-> regRdData == 8'h00)
        else $error("unmapped read not zero");
    clear_reads_a: assert property ($past(arst_n) && $past(regAddr) == 8'he1 |-> !regRdData[5])
        else $error("clear bit reads one");
    match_gate_a: assert property (ctrl_wr ##0 !regWrData[3] |=> ##1 !matchCaptureIrq)
        else $error("match irq while disabled");
    ovf_gate_a: assert property (ctrl_wr ##0 !regWrData[0] |=> ##1 !overflowIrq)
        else $error("overflow irq while disabled");
    ack_clears_a: assert property (overflowAck |=> ##1 !overflowIrq)
        else $error("overflow irq after service");
    capture_release_a: assert property (ctrl_wr ##0 regWrData[7:6] == 2'b01 |=> ##1 timerOutputOe_n)
        else $error("pin driven in capture mode");
    stop_holds_a: assert property (ctrl_wr ##0 regWrData[7:6] == 2'b00 && !regWrData[2]
        |=> ##2 $stable(timerOutputPin)[*3])
        else $error("pin moved while stopped");
endmodule

bind ettc_timer ettc_timer_chk i_chk (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .timerOutputPin(timerOutputPin), .timerOutputOe_n(timerOutputOe_n),
    .overflowAck(overflowAck), .overflowIrq(overflowIrq),
    .overflowVector(overflowVector), .matchCaptureIrq(matchCaptureIrq));

// ===== verif/test_eight_bit_timer_capture_pwm.sv
/* test_eight_bit_timer_capture_pwm: register-level tests of ettc_timer.
   assumes: checker bound in its own file; pins from ettc_pins_model. */
`timescale 1ns/1ns
module test_eight_bit_timer_capture_pwm;
    logic clk, arst_n, regWrite, overflowAck, extClkPin, capPin;
    logic timerOutputPin, timerOutputOe_n, overflowIrq, matchCaptureIrq;
    logic [7:0] regAddr, regWrData, regRdData, overflowVector, rv;
    int mismatches, nChecks, h, l;
    int divs[3] = '{0, 3, 15};
    ettc_timer i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .externalClockPin(extClkPin),
        .captureInputPin(capPin), .timerOutputPin(timerOutputPin),
        .timerOutputOe_n(timerOutputOe_n), .overflowAck(overflowAck),
        .overflowIrq(overflowIrq), .overflowVector(overflowVector),
        .matchCaptureIrq(matchCaptureIrq));
    ettc_pins_model i_pins (.extClkPin(extClkPin), .capPin(capPin));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkN(input string what, input int exp, input int got);
        nChecks++;
        if (got != exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        repeat (2) @(negedge clk);
        rv = regRdData;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // counts clocks until the output pin reaches v
    task automatic waitPin(input logic v, output int n);
        n = 0;
        while (timerOutputPin !== v && n < 30000)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    initial
    begin
        #600000;
        mismatches++;
        completeRun();
    end
    initial
    begin
        arst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        overflowAck = 1'b0;
        mismatches = 0;
        nChecks = 0;
        idle(8);
        arst_n = 1'b1;
        rd(8'he1); chk("control", 8'h00, rv);
        rd(8'he3); chk("reference", 8'hff, rv);
        rd(8'he5); chk("unmapped", 8'h00, rv);
        chk("vector", 8'hd0, overflowVector);
        $display("test reset done");
        wr(8'he3, 8'h02);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'he2, 8'(divs[i]));
            // second pass uses the spare mode code, which times as interval
            wr(8'he1, i == 1 ? 8'hac : 8'h2c);
            waitPin(~timerOutputPin, h);
            waitPin(~timerOutputPin, h);
            chkN("toggle period", 3 << (divs[i] > 12 ? 12 : divs[i]), h);
        end
        rd(8'he1); chk("control", 8'h0e, rv);
        chk("match irq", 8'h01, {7'h00, matchCaptureIrq});
        wr(8'he1, 8'h08);
        rd(8'he1); chk("control", 8'h08, rv);
        chk("match irq", 8'h00, {7'h00, matchCaptureIrq});
        $display("test interval done");
        wr(8'he2, 8'h00);
        wr(8'he3, 8'h40);
        wr(8'he1, 8'hc4);
        waitPin(1'b0, h);
        waitPin(1'b1, h);
        waitPin(1'b0, h);
        waitPin(1'b1, l);
        chkN("pwm high", 64, h);
        chkN("pwm period", 256, h + l);
        chk("pin driven", 8'h00, {7'h00, timerOutputOe_n});
        $display("test pwm done");
        for (int i = 0; i < 2; i++)
        begin
            wr(8'he1, 8'hc5);
            h = 0;
            while (overflowIrq !== 1'b1 && h < 300)
            begin
                @(negedge clk);
                h++;
            end
            chk("overflow irq", 8'h01, {7'h00, overflowIrq});
            wr(8'he1, 8'hc1);
            if (i == 0)
                wr(8'he6, 8'h00);
            else
            begin
                overflowAck = 1'b1;
                idle(1);
                overflowAck = 1'b0;
            end
            rd(8'he6); chk("overflow pending", 8'h00, rv);
            chk("overflow irq", 8'h00, {7'h00, overflowIrq});
        end
        $display("test overflow done");
        wr(8'he7, 8'h00);
        wr(8'he2, 8'h10);
        wr(8'he1, 8'h6c);
        i_pins.pulse(5, 24);
        idle(4);
        rd(8'he4); chk("counter", 8'h05, rv);
        i_pins.drive_cap(1'b1);
        idle(8);
        rd(8'he3); chk("captured", 8'h05, rv);
        chk("capture irq", 8'h01, {7'h00, matchCaptureIrq});
        chk("pin released", 8'h01, {7'h00, timerOutputOe_n});
        wr(8'he2, 8'h30);
        wr(8'he1, 8'h4c);
        i_pins.pulse(3, 8);
        idle(4);
        i_pins.drive_cap(1'b0);
        idle(8);
        rd(8'he3); chk("captured", 8'h08, rv);
        wr(8'he7, 8'h08);
        i_pins.drive_cap(1'b1);
        idle(8);
        // falling edge is the selected one, so only the port field stops it
        i_pins.drive_cap(1'b0);
        idle(8);
        rd(8'he3); chk("not captured", 8'h08, rv);
        i_pins.drive_cap(1'b1);
        wr(8'he1, 8'h6c);
        wr(8'he7, 8'h00);
        i_pins.drive_cap(1'b0);
        idle(8);
        rd(8'he3); chk("cleared capture", 8'h00, rv);
        $display("test capture done");
        completeRun();
    end
endmodule
